/* File: common/trig_exp_consts.svh */
/*
  Register offsets, field positions, reset values and timing counts for the
  hardware-trigger exposure controller. Assumes a 20 MHz core clock.
*/
`ifndef TRIG_EXP_CONSTS_SVH
`define TRIG_EXP_CONSTS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define REG_CTRL          8'h00
`define REG_EXP_RAW       8'h04
`define REG_TIME_BASE     8'h08
`define REG_STATUS        8'h0C
`define REG_IRQ_STATUS    8'h10
`define REG_IRQ_MASK      8'h14

// ********************************************************************
// Control fields
// ********************************************************************
`define CTRL_ENABLE_BIT   0
`define CTRL_FALLING_BIT  1
`define CTRL_WIDTH_BIT    2
`define CTRL_OVERLAP_BIT  3
`define CTRL_LINE_LSB     4
`define CTRL_LINE_MSB     5

// ********************************************************************
// Interrupt status fields
// ********************************************************************
`define IRQ_OVERTRIG_BIT  0
`define IRQ_FRAME_BIT     1
`define IRQ_WIDTH         2

// ********************************************************************
// Reset values and timing
// ********************************************************************
`define CTRL_RESET        32'h0000_0000
`define EXP_RAW_RESET     12'h064
`define TIME_BASE_US      20
`define CLK_MHZ           20
`define TIME_BASE_RESET   24'h00_0014

`endif

/* File: common/trig_exp_pkg.sv */
/*
  Types for the hardware-trigger exposure controller.
  Assumes trig_exp_consts.svh is available on the include path.
*/
package trig_exp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_EXPOSE,
    ST_HOLD
  } exp_state_t;

  typedef struct packed {
    logic       enable;
    logic       falling;
    logic       width_mode;
    logic       overlap;
    logic [1:0] line_sel;
  } ctrl_t;

  typedef struct packed {
    logic        awv;
    logic [7:0]  awaddr;
    logic        wv;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } wr_hold_t;

endpackage : trig_exp_pkg

/* File: hdl/trig_exp_ctrl.sv */
/*
  Exposure-start controller driven by an external hardware trigger line,
  with an AXI4-Lite register slave and a level interrupt.
  Assumes: trigger lines are asynchronous pins; readout_busy_in
  comes from sensor timing on the same clock.
*/
// Contract
// - With enable set, the selected input line acts as start trigger.
// - A polarity bit picks rising or falling edge as active event.
// - In waiting state, each active edge starts a frame acquisition.
// - Accepting a trigger leaves the waiting state at exposure start.
// - Waiting state re-enters by itself once a new trigger is acceptable.
// - One frame per accepted trigger; trigger period sets frame rate.
// - Edges arriving outside the waiting state are discarded.
// - Exactly two exposure modes, timed and pulse width, chosen by a bit.
// - Timed mode exposes from active edge for programmed exposure time.
// - Timed mode edge during exposure is ignored and flags overtrigger.
// - Width mode rising polarity exposes from rise to following fall.
// - Width mode falling polarity exposes from fall to following rise.
// - Width mode still times trigger-ready output from programmed time.
// - Width mode overlapped: pulse end during readout extends to its end.
// - Pulse ending after readout ends exposure at the pulse end.
// - Exposure equals raw count times time base, base defaulting 20 us.
`timescale 1ns/1ns
`default_nettype none
`include "trig_exp_consts.svh"

module trig_exp_ctrl
  import trig_exp_pkg::*;
#(
  parameter int LINES    = 4,
  parameter int RAW_W    = 12,
  parameter int BASE_W   = 24,
  parameter int CNT_W    = 40
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [LINES-1:0] trig_lines_in,
  input  wire logic             readout_busy_in,
  output logic                  exposure_out,
  output logic                  frame_start_out,
  output logic                  trigger_ready_out,
  output logic                  waiting_out,
  output logic                  overtrigger_out,
  output logic                  irq_out,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  // ********************************************************************
  // State record
  // ********************************************************************
  typedef struct packed {
    logic [LINES-1:0]      sync1;
    logic [LINES-1:0]      sync2;
    logic                  trig_prev;
    exp_state_t            state;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      rdy_cnt;
    logic                  pulse_done;
    ctrl_t                 ctrl;
    logic [RAW_W-1:0]      exp_raw;
    logic [BASE_W-1:0]     base_us;
    logic [`IRQ_WIDTH-1:0] irq_stat;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    wr_hold_t              wr;
    logic                  bvalid;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic                  exposure;
    logic                  frame_start;
    logic                  trig_ready;
    logic                  waiting;
    logic                  overtrig;
    logic                  irq;
  } state_t;

  localparam logic [CNT_W-1:0] CYC_PER_US = CNT_W'(`CLK_MHZ);

  state_t q;
  state_t d;

  logic             trig_lvl;
  logic             act_edge;
  logic             end_edge;
  logic [CNT_W-1:0] exp_cycles;
  logic             do_write;
  logic [31:0]      wmask;
  logic [31:0]      wval;
  logic [31:0]      cur;

  always_comb begin
    d          = q;
    wmask      = 32'h0000_0000;
    wval       = 32'h0000_0000;
    cur        = 32'h0000_0000;
    // ******************************************************************
    // Trigger input path
    // ******************************************************************
    // two-stage synchroniser
    d.sync1    = trig_lines_in;
    d.sync2    = q.sync1;
    trig_lvl   = q.sync2[q.ctrl.line_sel];
    d.trig_prev = trig_lvl;
    act_edge   = q.ctrl.falling ? (q.trig_prev & ~trig_lvl) : (~q.trig_prev & trig_lvl);
    end_edge   = q.ctrl.falling ? (~q.trig_prev & trig_lvl) : (q.trig_prev & ~trig_lvl);
    // raw times base, in clock cycles
    exp_cycles = CNT_W'(q.exp_raw) * CNT_W'(q.base_us) * CYC_PER_US;
    d.frame_start = 1'b0;
    d.overtrig    = 1'b0;

    // ******************************************************************
    // Exposure sequencer
    // ******************************************************************
    if (q.rdy_cnt != '0) begin
      d.rdy_cnt = q.rdy_cnt - CNT_W'(1);
    end
    case (q.state)
      ST_IDLE: begin
        if (q.ctrl.enable) begin
          d.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!q.ctrl.enable) begin
          d.state = ST_IDLE;
        // start on active edge, one frame each
        end else if (act_edge) begin
          d.state       = ST_EXPOSE;
          d.frame_start = 1'b1;
          d.cnt         = exp_cycles;
          d.rdy_cnt     = exp_cycles;
          d.pulse_done  = 1'b0;
        end
      end
      ST_EXPOSE: begin
        // edge while busy dropped, and flagged in timed mode
        if (act_edge && !q.ctrl.width_mode) begin
          d.overtrig = 1'b1;
        end
        if (!q.ctrl.width_mode) begin
          if (q.cnt <= CNT_W'(1)) begin
            d.state = ST_HOLD;
          end else begin
            d.cnt = q.cnt - CNT_W'(1);
          end
        end else if (end_edge || q.pulse_done) begin
          // extend while readout runs if overlap is set, else end now
          if (q.ctrl.overlap && readout_busy_in) begin
            d.pulse_done = 1'b1;
          end else begin
            d.state = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (act_edge) begin
          d.overtrig = 1'b1;
        end
        if (!readout_busy_in || q.ctrl.overlap) begin
          d.state = q.ctrl.enable ? ST_WAIT : ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    d.exposure   = (d.state == ST_EXPOSE);
    d.waiting    = (d.state == ST_WAIT);
    d.trig_ready = (d.state == ST_WAIT) && (d.rdy_cnt == '0);

    // ******************************************************************
    // AXI4-Lite slave
    // ******************************************************************
    if (s_axi_awvalid && !q.wr.awv) begin
      d.wr.awv    = 1'b1;
      d.wr.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wr.wv) begin
      d.wr.wv    = 1'b1;
      d.wr.wdata = s_axi_wdata;
      d.wr.wstrb = s_axi_wstrb;
    end
    do_write = q.wr.awv && q.wr.wv && !q.bvalid;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{q.wr.wstrb[i]}};
    end
    if (do_write) begin
      d.wr.awv  = 1'b0;
      d.wr.wv   = 1'b0;
      d.bvalid  = 1'b1;
      case (q.wr.awaddr)
        `REG_CTRL: begin
          cur  = {26'h000_0000, q.ctrl.line_sel, q.ctrl.overlap, q.ctrl.width_mode,
                  q.ctrl.falling, q.ctrl.enable};
          wval = (cur & ~wmask) | (q.wr.wdata & wmask);
          d.ctrl.enable     = wval[`CTRL_ENABLE_BIT];
          d.ctrl.falling    = wval[`CTRL_FALLING_BIT];
          d.ctrl.width_mode = wval[`CTRL_WIDTH_BIT];
          d.ctrl.overlap    = wval[`CTRL_OVERLAP_BIT];
          d.ctrl.line_sel   = wval[`CTRL_LINE_MSB:`CTRL_LINE_LSB];
        end
        `REG_EXP_RAW: begin
          wval      = (32'(q.exp_raw) & ~wmask) | (q.wr.wdata & wmask);
          d.exp_raw = wval[RAW_W-1:0];
        end
        `REG_TIME_BASE: begin
          wval      = (32'(q.base_us) & ~wmask) | (q.wr.wdata & wmask);
          d.base_us = wval[BASE_W-1:0];
        end
        `REG_IRQ_MASK: begin
          d.irq_mask = q.wr.wdata[`IRQ_WIDTH-1:0] & wmask[`IRQ_WIDTH-1:0];
          d.irq_mask = d.irq_mask | (q.irq_mask & ~wmask[`IRQ_WIDTH-1:0]);
        end
        default: begin
        end
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Set wins over write-one-to-clear
    if (do_write && q.wr.awaddr == `REG_IRQ_STATUS) begin
      d.irq_stat = q.irq_stat & ~(q.wr.wdata[`IRQ_WIDTH-1:0] & wmask[`IRQ_WIDTH-1:0]);
    end
    if (d.overtrig) begin
      d.irq_stat[`IRQ_OVERTRIG_BIT] = 1'b1;
    end
    if (d.frame_start) begin
      d.irq_stat[`IRQ_FRAME_BIT] = 1'b1;
    end
    d.irq = |(d.irq_stat & d.irq_mask);

    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      case (s_axi_araddr)
        `REG_CTRL:       d.rdata = {26'h000_0000, q.ctrl.line_sel, q.ctrl.overlap,
                                    q.ctrl.width_mode, q.ctrl.falling, q.ctrl.enable};
        `REG_EXP_RAW:    d.rdata = 32'(q.exp_raw);
        `REG_TIME_BASE:  d.rdata = 32'(q.base_us);
        `REG_STATUS:     d.rdata = {28'h000_0000, q.trig_ready, q.exposure, q.waiting,
                                    readout_busy_in};
        `REG_IRQ_STATUS: d.rdata = 32'(q.irq_stat);
        `REG_IRQ_MASK:   d.rdata = 32'(q.irq_mask);
        default:         d.rdata = 32'h0000_0000;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q         <= '0;
      q.state   <= ST_IDLE;
      q.exp_raw <= `EXP_RAW_RESET;
      q.base_us <= BASE_W'(`TIME_BASE_US);
    end else begin
      q <= d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign exposure_out      = q.exposure;
  assign frame_start_out   = q.frame_start;
  assign trigger_ready_out = q.trig_ready;
  assign waiting_out       = q.waiting;
  assign overtrigger_out   = q.overtrig;
  assign irq_out           = q.irq;
  assign s_axi_awready     = ~q.wr.awv;
  assign s_axi_wready      = ~q.wr.wv;
  assign s_axi_bvalid      = q.bvalid;
  assign s_axi_bresp       = 2'b00;
  assign s_axi_arready     = ~q.rvalid;
  assign s_axi_rvalid      = q.rvalid;
  assign s_axi_rdata       = q.rdata;
  assign s_axi_rresp       = 2'b00;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence s_accept;
    q.state == ST_WAIT && q.ctrl.enable && act_edge;
  endsequence

  property p_start_on_edge;
    @(posedge clk_in) disable iff (!resetn_in) s_accept |=> frame_start_out && exposure_out;
  endproperty
  a_start_on_edge: assert property (p_start_on_edge) else $error("Edge in wait did not start");

  property p_leave_wait;
    @(posedge clk_in) disable iff (!resetn_in) frame_start_out |-> !waiting_out;
  endproperty
  a_leave_wait: assert property (p_leave_wait) else $error("Still waiting after start");

  property p_no_start_busy;
    @(posedge clk_in) disable iff (!resetn_in) $past(q.state) != ST_WAIT |-> !frame_start_out;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("Start outside wait");

  property p_overtrig;
    @(posedge clk_in) disable iff (!resetn_in)
      q.state == ST_EXPOSE && !q.ctrl.width_mode && act_edge |=> overtrigger_out;
  endproperty
  a_overtrig: assert property (p_overtrig) else $error("Overtrigger not flagged");

  // Twenty cycles is one raw unit on a one microsecond base
  sequence s_expose_20;
    exposure_out [*8] ##1 exposure_out [*8] ##1 exposure_out [*4] ##1 !exposure_out;
  endsequence

  sequence s_unready_20;
    !trigger_ready_out [*8] ##1 !trigger_ready_out [*8] ##1 !trigger_ready_out [*4];
  endsequence

  property p_timed_len;
    @(posedge clk_in) disable iff (!resetn_in)
      s_accept and (!q.ctrl.width_mode && exp_cycles == CNT_W'(20)) |=> s_expose_20;
  endproperty
  a_timed_len: assert property (p_timed_len) else $error("Timed exposure length wrong");

  property p_ready_time;
    @(posedge clk_in) disable iff (!resetn_in)
      s_accept and (exp_cycles == CNT_W'(20)) |=> s_unready_20;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("Trigger ready too early");

  property p_start_once;
    @(posedge clk_in) disable iff (!resetn_in) frame_start_out |=> !frame_start_out;
  endproperty
  a_start_once: assert property (p_start_once) else $error("Start pulse repeated");

  property p_width_end;
    @(posedge clk_in) disable iff (!resetn_in)
      q.state == ST_EXPOSE && q.ctrl.width_mode && end_edge && !readout_busy_in |=> !exposure_out;
  endproperty
  a_width_end: assert property (p_width_end) else $error("Pulse end missed");

  property p_extend;
    @(posedge clk_in) disable iff (!resetn_in)
      q.state == ST_EXPOSE && q.ctrl.width_mode && q.ctrl.overlap && readout_busy_in |=> exposure_out;
  endproperty
  a_extend: assert property (p_extend) else $error("Exposure cut during readout");

  property p_rewait;
    @(posedge clk_in) disable iff (!resetn_in)
      q.state == ST_HOLD && q.ctrl.enable && !readout_busy_in |=> waiting_out;
  endproperty
  a_rewait: assert property (p_rewait) else $error("Did not return to wait");

endmodule : trig_exp_ctrl
`default_nettype wire

/* File: verification/trig_src_model.sv */
/*
  External trigger source: one line, one pulse of width_in cycles per request.
  Assumes the bench raises fire_in for one cycle to ask for a pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module trig_src_model (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        fire_in,
  input  wire logic        falling_in,
  input  wire logic [15:0] width_in,
  output logic             line_out
);
  logic [15:0] left_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      left_q <= 16'h0000;
    end else if (fire_in && left_q == 16'h0000) begin
      left_q <= width_in;
    end else if (left_q != 16'h0000) begin
      left_q <= left_q - 16'h0001;
    end
  end
  // Line is driven at all times, idle at the inactive level
  assign line_out = falling_in ^ (left_q != 16'h0000);
endmodule : trig_src_model
`default_nettype wire

/* File: verification/hw_trigger_exposure_control_test.sv */
/*
  Self-checking bench: registers over AXI4-Lite, trigger shots, interrupt.
  Assumes trig_exp_consts.svh on the include path and trig_src_model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "trig_exp_consts.svh"
module hw_trigger_exposure_control_test;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        fire = 1'b0;
  logic        falling = 1'b0;
  logic        busy = 1'b0;
  logic        en_q = 1'b0;
  logic [1:0]  route = 2'h1;
  logic [15:0] width = 16'h0000;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        line, exposure, frame_start, trig_ready, waiting, overtrig, irq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, v;
  logic [3:0]  sel_mask, lines;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  assign sel_mask = 4'h1 << route;
  assign lines    = ({4{falling}} & ~sel_mask) | ({4{line}} & sel_mask);

  trig_src_model src (.clk_in(clk_in), .resetn_in(resetn_in), .fire_in(fire),
    .falling_in(falling), .width_in(width), .line_out(line));

  trig_exp_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in), .trig_lines_in(lines),
    .readout_busy_in(busy), .exposure_out(exposure), .frame_start_out(frame_start),
    .trigger_ready_out(trig_ready), .waiting_out(waiting), .overtrigger_out(overtrig),
    .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  always #25 clk_in = ~clk_in;

  task automatic close_out;
    $display("compares %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Worst case run is about a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  // ********************************************************************
  // Bus tasks: sample handshakes at the falling edge, act on the rising
  // ********************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    logic [1:0] rsp;
    b_t = 1'b0;
    rsp = 2'b11;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (int n = 0; n < 50 && !b_t; n++) begin
      @(negedge clk_in);
      aw_t = awvalid & (awready === 1'b1);
      w_t = wvalid & (wready === 1'b1);
      b_t = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge clk_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("write answer", 32'h0000_0001, {31'h0, b_t});
    chk("write resp", 32'h0000_0000, 32'(rsp));
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar_t, r_t;
    logic [1:0] rsp;
    r_t = 1'b0;
    rsp = 2'b11;
    @(posedge clk_in);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int n = 0; n < 50 && !r_t; n++) begin
      @(negedge clk_in);
      ar_t = arvalid & (arready === 1'b1);
      r_t = (rvalid === 1'b1);
      d = rdata;
      rsp = rresp;
      @(posedge clk_in);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("read answer", 32'h0000_0001, {31'h0, r_t});
    chk("read resp", 32'h0000_0000, 32'(rsp));
  endtask : rd

  // Control word, then move the pin to its new idle level
  task automatic cfg(input logic en, fl, wm, ov, input logic [1:0] sel, rt);
    wr(`REG_CTRL, {26'h0, sel, ov, wm, fl, en});
    en_q = en;
    @(posedge clk_in);
    route <= rt;
    falling <= fl;
    repeat (8) @(posedge clk_in);
  endtask : cfg

  // One pulse, optional second pulse at gap, readout busy for the first
  // busy cycles; xlen below zero asks only for a stretched exposure
  task automatic shot(input logic [15:0] w, input int gap, busy_n, xlen,
                      input logic xfs, xot);
    int len;
    int fs;
    logic ot, clash;
    len = 0;
    fs = 0;
    ot = 1'b0;
    clash = 1'b0;
    @(posedge clk_in);
    width <= w;
    fire <= 1'b1;
    busy <= (busy_n > 0);
    for (int i = 1; i < 100; i++) begin
      @(posedge clk_in);
      fire <= (i == gap);
      if (i == busy_n) busy <= 1'b0;
      #1;
      len += (exposure === 1'b1);
      fs += (frame_start === 1'b1);
      ot |= (overtrig === 1'b1);
      clash |= (exposure === 1'b1) && (waiting !== 1'b0);
    end
    if (xlen >= 0) chk("exposure cycles", 32'(xlen), 32'(len));
    if (xlen < 0) chk("stretched", 32'h1, {31'h0, len > 32'(w) + 8});
    chk("frames", {31'h0, xfs}, 32'(fs));
    chk("overtrigger", {31'h0, xot}, {31'h0, ot});
    chk("waiting while exposing", 32'h0, {31'h0, clash});
    chk("waiting again", {31'h0, en_q}, {31'h0, waiting});
    chk("trigger ready", {31'h0, en_q}, {31'h0, trig_ready});
    $display("shot done, width %0d, mismatches %0d", w, num_errors);
  endtask : shot

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(`REG_CTRL, v);
    chk("ctrl reset", `CTRL_RESET, v);
    rd(`REG_EXP_RAW, v);
    chk("raw reset", 32'h0000_0064, v);
    rd(`REG_TIME_BASE, v);
    chk("base reset", 32'h0000_0014, v);
    rd(`REG_IRQ_MASK, v);
    chk("mask reset", 32'h0000_0000, v);
    rd(`REG_STATUS, v);
    chk("status reset", 32'h0000_0000, v);
    rd(8'h1C, v);
    chk("unmapped", 32'h0000_0000, v);
    // one unit of 20 cycles, so exposures stay short
    wr(`REG_EXP_RAW, 32'h0000_0001);
    wr(`REG_TIME_BASE, 32'h0000_0001);
    rd(`REG_EXP_RAW, v);
    chk("raw", 32'h0000_0001, v);
    wr(`REG_IRQ_MASK, 32'h0000_0001);
    $display("register test done");
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 2'h1);
    shot(16'h0003, 0, 0, 0, 1'b0, 1'b0);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 2'h1);
    shot(16'h0003, 0, 0, 0, 1'b0, 1'b0);
    rd(`REG_STATUS, v);
    chk("status waiting", 32'h0000_000A, v);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 2'h1);
    shot(16'h0003, 0, 0, 20, 1'b1, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    shot(16'h0003, 8, 0, 20, 1'b1, 1'b1);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(`REG_IRQ_STATUS, v);
    chk("irq status", 32'h0000_0003, v);
    wr(`REG_IRQ_STATUS, 32'h0000_0003);
    chk("irq cleared", 32'h0, {31'h0, irq});
    cfg(1'b1, 1'b1, 1'b0, 1'b0, 2'h3, 2'h3);
    shot(16'h0003, 0, 0, 20, 1'b1, 1'b0);
    // programmed time of 20 cycles stays below the 25 and 30 cycle pulses
    cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
    shot(16'h001E, 0, 0, 30, 1'b1, 1'b0);
    cfg(1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0);
    shot(16'h0019, 0, 0, 25, 1'b1, 1'b0);
    cfg(1'b1, 1'b0, 1'b1, 1'b1, 2'h1, 2'h1);
    shot(16'h000A, 0, 45, -1, 1'b1, 1'b0);
    shot(16'h001E, 0, 5, 30, 1'b1, 1'b0);
    close_out();
  end
endmodule : hw_trigger_exposure_control_test
`default_nettype wire
